//--- inc/code_consts.svh
// Constants for the clock output driver enable block.
`ifndef CODE_CONSTS_SVH
`define CODE_CONSTS_SVH
`define CODE_OFS_CTRL 4'h0
`define CODE_OFS_CNFG 4'h1
`define CODE_OFS_STAT 4'h2
`define CODE_OFS_GRP 4'h3
`define CODE_CTRL_RESET 8'h06
`define CODE_CNFG_RESET 8'h00
`define CODE_BIT_PD 7
`define CODE_BIT_OEMODE 6
`define CODE_GRP_HI 5
`define CODE_GRP_LO 3
`define CODE_DST_HI 2
`define CODE_DST_LO 1
`define CODE_BIT_DIS 0
`define CODE_GRP_MAX 3'h4
`define CODE_GRP_NONE 3'h5
`define CODE_GRP_FREE 3'h7
`define CODE_DST_HL 2'h0
`define CODE_DST_LH 2'h1
`define CODE_DST_Z 2'h2
`define CODE_DST_LL 2'h3
`define CODE_TYPE_HCSL 2'h0
`define CODE_TYPE_CMOS 2'h3
`define CODE_STOP_NS 1000
`define CODE_CLK_NS 40
`define CODE_STOP_CYC ((`CODE_STOP_NS / `CODE_CLK_NS) - 1)
`endif

//--- inc/code_pkg.sv
// Types shared by the clock output driver enable block.
package code_pkg;
    typedef struct packed {
        logic pd;
        logic async_oe;
        logic [2:0] group;
        logic [1:0] dis_state;
        logic dis;
    } code_ctrl_s;
    typedef struct packed {
        logic true_out;
        logic true_oe_n;
        logic comp_out;
        logic comp_oe_n;
    } code_pins_s;
    typedef enum logic [1:0] {CODE_RUN, CODE_STOP} code_state_e;
endpackage

//--- core/code_sync2.sv
// Two-stage synchroniser for a level coming from outside the clock domain.
module code_sync2
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    logic stage1;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

//--- core/code_driver_enable.sv
// Enable, power and disabled-level control for one clock output driver.
// Functional notes
// - Power-down bit 7 set powers the driver down; clear keeps it powered.
// - Timing select 0: enable changes land one divider cycle later.
// - Timing select 1: enable changes apply at once, glitches possible.
// - Group codes 0 to 4 pick enable groups; code 5 means no group.
// - Group code 7 runs regardless of lock, global bit or global pin.
// - Disable bit still stops an output excluded from global enables.
// - Disabled level: 0 high/low, 1 low/high, 2 float, 3 low/low (high/low on LVDS types).
// - Disable bit 0 set turns off both drivers, or the single CMOS one.
// - Disable bit clear enables unless group, global, lock or power-down stop it.
// - Resynchronised free-running divider stops the output under 1 us.
// - Type 0 low-power HCSL, 1 and 2 LVDS, 3 single-ended CMOS.
`include "code_consts.svh"
module code_driver_enable
    import code_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic div_clk_en,
    input wire logic div_resync,
    input wire logic pll_locked,
    input wire logic global_oe_pin,
    input wire logic [4:0] group_oe,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic driver_power_down,
    output logic true_output_pin,
    output logic true_output_oe_n,
    output logic complement_output_pin,
    output logic complement_output_oe_n,
    output logic [1:0] driver_type
);
    code_ctrl_s ctrl;
    logic [7:0] cnfg;
    logic goe_pin_s;
    logic locked_s;
    logic raw_en;
    logic sync_en;
    logic eff_en;
    logic [4:0] stop_cnt;
    code_state_e state;
    code_pins_s next_pins;

    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    // Pins and the lock flag come from other domains.
    code_sync2 u_goe
    (
        .clk(clk),
        .resetn(resetn),
        .din(global_oe_pin),
        .dout(goe_pin_s)
    );
    code_sync2 u_lock
    (
        .clk(clk),
        .resetn(resetn),
        .din(pll_locked),
        .dout(locked_s)
    );

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    // Group select: codes above four carry no group enable.
    function automatic logic group_on(input logic [2:0] g,
                                      input logic [4:0] oe);
        if (g <= `CODE_GRP_MAX)
            group_on = oe[g];
        else
            group_on = 1'b1;
    endfunction

    // Control register; cnfg bit 0 is the global enable bit, 2:1 the type.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= `CODE_CTRL_RESET;
            cnfg <= `CODE_CNFG_RESET;
        end
        else if (wr)
        begin
            if (addr == `CODE_OFS_CTRL)
                ctrl <= wdata;
            else if (addr == `CODE_OFS_CNFG)
                cnfg <= {5'h00, wdata[2:0]};
        end
    end

    // Read port answers one cycle later; unmapped reads return zero.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= 8'h00;
        else if (rd)
        begin
            unique case (addr)
                `CODE_OFS_CTRL: rdata <= ctrl;
                `CODE_OFS_CNFG: rdata <= cnfg;
                `CODE_OFS_STAT: rdata <= {5'h00, state == CODE_STOP,
                                          sync_en, eff_en};
                `CODE_OFS_GRP: rdata <= {3'h0, group_oe};
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    //------------------------------------------------------------
    // Enable logic
    //------------------------------------------------------------
    // Free-running outputs ignore lock and both global enables.
    always_comb
    begin
        if (ctrl.group == `CODE_GRP_FREE)
            raw_en = !ctrl.pd && !ctrl.dis;
        else
            raw_en = !ctrl.pd && !ctrl.dis && locked_s
                     && cnfg[0] && goe_pin_s
                     && group_on(ctrl.group, group_oe);
    end

    // Synchronous mode samples the enable on a divider tick.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sync_en <= 1'b0;
        else if (div_clk_en)
            sync_en <= raw_en;
    end

    // Asynchronous mode bypasses the tick; runt pulses are accepted.
    assign eff_en = (ctrl.async_oe ? raw_en : sync_en)
                    && !ctrl.pd && state == CODE_RUN;

    //------------------------------------------------------------
    // Resync stop
    //------------------------------------------------------------
    // A resync pauses the output for a bounded time, under one microsecond.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= CODE_RUN;
            stop_cnt <= 5'h00;
        end
        else
        begin
            unique case (state)
                CODE_RUN:
                    if (div_resync)
                    begin
                        state <= CODE_STOP;
                        stop_cnt <= 5'(`CODE_STOP_CYC - 1);
                    end
                CODE_STOP:
                    if (stop_cnt == 5'h00)
                        state <= CODE_RUN;
                    else
                        stop_cnt <= stop_cnt - 5'h01;
                default: state <= CODE_RUN;
            endcase
        end
    end

    //------------------------------------------------------------
    // Pin levels
    //------------------------------------------------------------
    // Running: toggle on divider ticks; disabled: hold the chosen level.
    always_comb
    begin
        next_pins = '0;
        if (eff_en)
        begin
            next_pins.true_out = div_clk_en ? !true_output_pin
                                            : true_output_pin;
            next_pins.comp_out = !next_pins.true_out;
            if (cnfg[2:1] == `CODE_TYPE_CMOS)
                next_pins.comp_oe_n = 1'b1;
        end
        else
        begin
            unique case (ctrl.dis_state)
                `CODE_DST_HL: next_pins.true_out = 1'b1;
                `CODE_DST_LH: next_pins.comp_out = 1'b1;
                `CODE_DST_Z:
                begin
                    next_pins.true_oe_n = 1'b1;
                    next_pins.comp_oe_n = 1'b1;
                end
                `CODE_DST_LL:
                    // LVDS types cannot hold low/low and hold high/low.
                    next_pins.true_out = cnfg[2:1] != `CODE_TYPE_HCSL
                        && cnfg[2:1] != `CODE_TYPE_CMOS;
            endcase
        end
    end

    // All pin outputs come straight from flip-flops.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            true_output_pin <= 1'b0;
            complement_output_pin <= 1'b0;
            true_output_oe_n <= 1'b0;
            complement_output_oe_n <= 1'b0;
            driver_power_down <= 1'b0;
            driver_type <= `CODE_TYPE_HCSL;
        end
        else
        begin
            true_output_pin <= next_pins.true_out;
            complement_output_pin <= next_pins.comp_out;
            true_output_oe_n <= next_pins.true_oe_n;
            complement_output_oe_n <= next_pins.comp_oe_n;
            driver_power_down <= ctrl.pd;
            driver_type <= cnfg[2:1];
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    a_pd_follows: assert property (@(posedge clk) disable iff (!resetn)
        $changed(ctrl.pd) |=> driver_power_down == $past(ctrl.pd))
        else $error("Power-down pin did not follow its bit.");
    a_sync_tick: assert property (@(posedge clk) disable iff (!resetn)
        !div_clk_en |=> $stable(sync_en))
        else $error("Synchronous enable moved without a divider tick.");
    a_async_now: assert property (@(posedge clk) disable iff (!resetn)
        ctrl.async_oe && state == CODE_RUN |-> eff_en == raw_en)
        else $error("Asynchronous enable did not track at once.");
    a_group_gate: assert property (@(posedge clk) disable iff (!resetn)
        ctrl.group <= `CODE_GRP_MAX && !group_oe[ctrl.group] |-> !raw_en)
        else $error("Disabled group left the output enabled.");
    a_free_run: assert property (@(posedge clk) disable iff (!resetn)
        ctrl.group == `CODE_GRP_FREE && !ctrl.pd && !ctrl.dis |-> raw_en)
        else $error("Free-running output was gated.");
    // In synchronous mode the disable only lands on the next divider tick.
    a_dis_wins: assert property (@(posedge clk) disable iff (!resetn)
        ctrl.dis |-> !raw_en && (!ctrl.async_oe || !eff_en))
        else $error("Disable bit did not stop the output.");
    a_dis_tick: assert property (@(posedge clk) disable iff (!resetn)
        ctrl.dis && div_clk_en |=> !sync_en)
        else $error("Disable was not taken on the divider tick.");
    a_hiz_hold: assert property (@(posedge clk) disable iff (!resetn)
        !eff_en && ctrl.dis_state == `CODE_DST_Z |=> true_output_oe_n
        && complement_output_oe_n)
        else $error("Float state not driven to high impedance.");
    a_stop_bound: assert property (@(posedge clk) disable iff (!resetn)
        state == CODE_RUN && div_resync |=> ##[0:24] state == CODE_RUN)
        else $error("Resync stop lasted a microsecond or more.");
endmodule

//--- testbench/code_rx_model.sv
// Receiver model that watches the output clock pins.
module code_rx_model
    import code_pkg::*;
(
    input wire logic clk,
    input wire code_pins_s pins,
    output int rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev = 1'b0;
    logic lvl;
    // A released line shows the inverse of its last level, so a stale
    // value can never pass for a driven one.
    always_comb lvl = pins.true_oe_n ? ~prev : pins.true_out;
    initial rises = 0;
    // Rising edges are counted only while the pin is really driven.
    always @(posedge clk)
    begin
        prev <= lvl;
        if (!pins.true_oe_n && !prev && lvl)
            rises <= rises + 1;
    end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the clock output driver enable block.
`define CHK(g, e) chk(8'(g), 8'(e))
module tb_top
    import code_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, resetn = 0, dce = 0, drs = 0, pll = 0, gpin = 0;
    logic wr = 0, rd = 0, pd, tp, toe, cp, coe, tick = 0;
    logic [4:0] goe = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, rdata, d;
    logic [1:0] dtype;
    logic [3:0] exp_dis [4] = '{4'h8, 4'h2, 4'h0, 4'h0};
    code_pins_s p;
    int fails = 0, num_checks = 0, cyc = 0, r0, rises, k;
    code_driver_enable uut (.clk(clk), .resetn(resetn),
        .div_clk_en(dce), .div_resync(drs), .pll_locked(pll),
        .global_oe_pin(gpin), .group_oe(goe), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .driver_power_down(pd), .true_output_pin(tp),
        .true_output_oe_n(toe), .complement_output_pin(cp),
        .complement_output_oe_n(coe), .driver_type(dtype));
    assign p = {tp, toe, cp, coe};
    code_rx_model rx (.clk(clk), .pins(p), .rises(rises));
    // Clock at 25 MHz.
    initial
    begin
        forever #20 clk = ~clk;
    end
    // Divider ticks every other cycle; the cycle ceiling cuts a hang.
    always @(posedge clk)
    begin
        dce <= tick && !dce;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic r(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 d = rdata;
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1;
        r(0);
        `CHK(d, 8'h06);
        w(4'hF, 8'hFF);
        r(4'hF);
        `CHK(d, 0);
        r(0);
        `CHK(d, 8'h06);
        for (k = 0; k < 4; k++)
        begin
            w(1, 8'(k * 2));
            repeat (2) @(posedge clk);
            `CHK(dtype, k);
        end
        $display("test registers done");
        w(1, 0);
        for (k = 0; k < 4; k++)
        begin
            w(0, 8'(k * 2 + 1));
            repeat (3) @(posedge clk);
            if (k == 2)
                `CHK({toe, coe}, 2'b11);
            else
                `CHK(p, exp_dis[k]);
        end
        w(1, 8'h02);
        w(0, 8'h07);
        repeat (3) @(posedge clk);
        `CHK(p, 4'h8);
        w(0, 8'h81);
        repeat (3) @(posedge clk);
        `CHK(pd, 1);
        w(0, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(pd, 0);
        $display("test disabled levels done");
        // Free running with lock and global enables all low.
        w(1, 0);
        w(0, 8'h38);
        tick <= 1;
        repeat (6) @(posedge clk);
        r0 = rises;
        repeat (40) @(posedge clk);
        `CHK(rises - r0 >= 8, 1);
        @(negedge clk);
        `CHK(cp, !tp);
        w(0, 8'h39);
        repeat (6) @(posedge clk);
        `CHK(p, 4'h8);
        r0 = rises;
        repeat (20) @(posedge clk);
        `CHK(rises == r0, 1);
        // A resync stops the output for less than 25 cycles.
        w(0, 8'h38);
        repeat (6) @(posedge clk);
        drs <= 1;
        @(posedge clk);
        drs <= 0;
        r(2);
        `CHK(d[2], 1);
        r0 = rises;
        repeat (10) @(posedge clk);
        `CHK(rises == r0, 1);
        repeat (16) @(posedge clk);
        r(2);
        `CHK(d[2], 0);
        r0 = rises;
        repeat (20) @(posedge clk);
        `CHK(rises - r0 >= 4, 1);
        $display("test free run done");
        // Synchronous enable waits for a tick; asynchronous does not.
        tick <= 0;
        w(0, 8'h3B);
        repeat (4) @(posedge clk);
        r(2);
        `CHK(d[1:0], 2'b11);
        w(0, 8'h3A);
        repeat (6) @(posedge clk);
        `CHK(cp, !tp);
        w(0, 8'h7B);
        repeat (3) @(posedge clk);
        r(2);
        `CHK(d[0], 0);
        w(0, 8'h7A);
        repeat (3) @(posedge clk);
        r(2);
        `CHK(d[0], 1);
        $display("test timing done");
        pll <= 1;
        gpin <= 1;
        w(1, 8'h01);
        for (k = 0; k < 5; k++)
        begin
            w(0, 8'(k * 8 + 64));
            goe <= 5'(1 << k);
            repeat (6) @(posedge clk);
            r(2);
            `CHK(d[0], 1);
            goe <= ~5'(1 << k);
            repeat (6) @(posedge clk);
            r(2);
            `CHK(d[0], 0);
        end
        w(0, 8'h68);
        goe <= 0;
        repeat (6) @(posedge clk);
        r(2);
        `CHK(d[0], 1);
        r(3);
        `CHK(d, 0);
        pll <= 0;
        repeat (6) @(posedge clk);
        r(2);
        `CHK(d[0], 0);
        pll <= 1;
        w(1, 0);
        repeat (6) @(posedge clk);
        r(2);
        `CHK(d[0], 0);
        $display("test groups done");
        give_verdict();
    end
endmodule
